// File: src/dtb_regs.svh
`ifndef DTB_REGS_SVH
`define DTB_REGS_SVH

`define DTB_AW          8
`define DTB_OFF_CTRL0   8'h00
`define DTB_OFF_CTRL1   8'h04
`define DTB_OFF_STAT    8'h08
`define DTB_OFF_COUNT   8'h0c
`define DTB_OFF_PERIOD  8'h10
`define DTB_OFF_DUTY1   8'h14
`define DTB_OFF_DUTY2   8'h18

`define DTB_C0_RUN      0
`define DTB_C0_MODE     2:1
`define DTB_C0_TRIG     4:3
`define DTB_C0_CLR      5
`define DTB_C0_SRC      6
`define DTB_C0_PSC      8:7

`define DTB_C1_SEL0     2:0
`define DTB_C1_INV0     3
`define DTB_C1_SEL1     6:4
`define DTB_C1_INV1     7

`define DTB_ST_OVF      0
`define DTB_ST_IE       1
`define DTB_ST_PWM0     2
`define DTB_ST_PWM1     3
`define DTB_ST_DOWN     4

`define DTB_RST_PERIOD  16'hffff
`define DTB_RST_DUTY    16'h0000

`define DTB_WAVE_16A    3'h0
`define DTB_WAVE_16B    3'h1
`define DTB_WAVE_8LO    3'h2
`define DTB_WAVE_8HI    3'h3

`define DTB_RESP_OKAY   2'h0
`define DTB_RESP_DECERR 2'h3

`endif

// File: src/dtb_pkg.sv
`include "dtb_regs.svh"

package dtb_pkg;

    typedef enum logic [1:0] {
        DTB_M16  = 2'h0,
        DTB_M17  = 2'h1,
        DTB_M8X2 = 2'h2,
        DTB_M88  = 2'h3
    } dtb_mode_t;

    typedef enum logic [1:0] {
        DTB_TRG_ALWAYS = 2'h0,
        DTB_TRG_RISE   = 2'h1,
        DTB_TRG_FALL   = 2'h2,
        DTB_TRG_ANY    = 2'h3
    } dtb_trig_t;

    typedef enum logic [1:0] {
        DTB_UP   = 2'b01,
        DTB_DOWN = 2'b10
    } dtb_dir_t;

    typedef struct packed {
        logic [`DTB_AW-1:0] addr;
        logic [31:0]        data;
        logic [3:0]         strb;
    } dtb_wreq_t;

    typedef struct packed {
        logic               awRdy;
        logic               wRdy;
        logic               awHeld;
        logic               wHeld;
        dtb_wreq_t          req;
        logic               wrEn;
        logic               bValid;
        logic [1:0]         bResp;
        logic               arRdy;
        logic               rPend;
        logic [`DTB_AW-1:0] rAddr;
        logic               rValid;
        logic [31:0]        rData;
        logic [1:0]         rResp;
    } dtb_axi_st_t;

    typedef struct packed {
        logic        run;
        dtb_mode_t   mode;
        dtb_trig_t   trig;
        logic        clrReq;
        logic        srcExt;
        logic [1:0]  psc;
        logic [2:0]  sel0;
        logic        inv0;
        logic [2:0]  sel1;
        logic        inv1;
        logic        ovf;
        logic        irqEn;
        logic [15:0] period;
        logic [15:0] duty1;
        logic [15:0] duty2;
        logic [15:0] cnt;
        dtb_dir_t    dir;
        logic        armed;
        logic [2:0]  pscCnt;
        logic        extPrev;
        logic        trigPrev;
        logic        raw0;
        logic        raw1;
        logic        pwmOut0;
        logic        pwmOut1;
        logic        irq;
    } dtb_tmr_st_t;

endpackage : dtb_pkg

// File: src/dtb_sync3.sv
`timescale 1ns/1ps

module dtb_sync3 #(
    parameter int W = 2
) (
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Asynchronous inputs and their filtered levels.
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinLvl
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } dtb_sync_st_t;

    dtb_sync_st_t st;
    dtb_sync_st_t n;
    logic [W-1:0] agree;

    // A level change is taken only once the second and third stages agree.
    always_comb begin
        n     = st;
        n.s1  = pinIn;
        n.s2  = st.s1;
        n.s3  = st.s2;
        agree = st.s2 ~^ st.s3;
        n.lvl = (agree & st.s3) | (~agree & st.lvl);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    assign pinLvl = st.lvl;

endmodule : dtb_sync3

// File: src/dtb_axi_slave.sv
`timescale 1ns/1ps
`include "dtb_regs.svh"

module dtb_axi_slave (
    // Clock and reset.
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // AXI4-Lite write channels.
    input  wire logic [`DTB_AW-1:0] s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [`DTB_AW-1:0] s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Register file side.
    output logic                    wrEn,
    output dtb_pkg::dtb_wreq_t      wrReq,
    input  wire logic               wrOk,
    output logic [`DTB_AW-1:0]      rdAddr,
    input  wire logic [31:0]        rdData,
    input  wire logic               rdOk
);
    dtb_pkg::dtb_axi_st_t st;
    dtb_pkg::dtb_axi_st_t n;

    always_comb begin
        n      = st;
        n.wrEn = 1'b0;
        if (s_axi_awvalid && st.awRdy) begin
            n.awHeld   = 1'b1;
            n.req.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wRdy) begin
            n.wHeld    = 1'b1;
            n.req.data = s_axi_wdata;
            n.req.strb = s_axi_wstrb;
        end
        if (st.bValid && s_axi_bready) begin
            n.bValid = 1'b0;
        end
        // The write address stays put until the response is taken, so the
        // register file sees a stable request while the strobe is high.
        if (st.awHeld && st.wHeld && !st.bValid) begin
            n.wrEn   = 1'b1;
            n.bValid = 1'b1;
            n.bResp  = wrOk ? `DTB_RESP_OKAY : `DTB_RESP_DECERR;
            n.awHeld = 1'b0;
            n.wHeld  = 1'b0;
        end
        n.awRdy = !n.awHeld && !n.bValid;
        n.wRdy  = !n.wHeld && !n.bValid;
        if (s_axi_arvalid && st.arRdy) begin
            n.rAddr = s_axi_araddr;
            n.rPend = 1'b1;
        end
        if (st.rPend) begin
            n.rPend  = 1'b0;
            n.rValid = 1'b1;
            n.rData  = rdData;
            n.rResp  = rdOk ? `DTB_RESP_OKAY : `DTB_RESP_DECERR;
        end
        if (st.rValid && s_axi_rready) begin
            n.rValid = 1'b0;
        end
        n.arRdy = !n.rPend && !n.rValid;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    assign s_axi_awready = st.awRdy;
    assign s_axi_wready  = st.wRdy;
    assign s_axi_bresp   = st.bResp;
    assign s_axi_bvalid  = st.bValid;
    assign s_axi_arready = st.arRdy;
    assign s_axi_rdata   = st.rData;
    assign s_axi_rresp   = st.rResp;
    assign s_axi_rvalid  = st.rValid;
    assign wrEn          = st.wrEn;
    assign wrReq         = st.req;
    assign rdAddr        = st.rAddr;

endmodule : dtb_axi_slave

// File: src/dtb_timer.sv
// Function
// - Mode 00: 16-bit up, flag and clear at period.
// - Mode 01: up to period, down to zero, flag.
// - Mode 10: low byte up, flag and clear.
// - Mode 10: high byte clears at match, no flag.
// - Mode 11: low match flags, bumps high, clears low.
// - Mode 11: high byte wraps 255 to zero.
// - Flag with enable requests interrupt.
// - Clear bit zeroes counter, then self-clears.
// - Enable bit starts and stops counting.
// - Register reads have no side effects.
// - Counter read-only; compare writes keep count.
// - Control writes keep the count running.
// - Counter beyond period clears and restarts, except while mode 01 counts down; modes 10 and 11 compare per byte, and mode 11 never clears the high byte.
// - Trigger select gates start; 00 always.
// - Clock source select feeds 2-bit prescaler.
// - Two duty compares, two selectable invertible outputs.
// - Wave 000: high at duty, low at period.
// - Disabling the timer stops PWM outputs.
`timescale 1ns/1ps
`include "dtb_regs.svh"

module dtb_timer (
    // Clock and reset.
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // AXI4-Lite write channels.
    input  wire logic [`DTB_AW-1:0] s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [`DTB_AW-1:0] s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Pins.
    input  wire logic               extClkPin,
    input  wire logic               trigPin,
    output logic                    pwmOut0,
    output logic                    pwmOut1,
    output logic                    irqReq
);
    dtb_pkg::dtb_tmr_st_t st;
    dtb_pkg::dtb_tmr_st_t n;
    dtb_pkg::dtb_wreq_t   wrReq;
    logic                 wrEn;
    logic [`DTB_AW-1:0]   rdAddr;
    logic [1:0]           pinLvl;

    function automatic logic regHit(input logic [`DTB_AW-1:0] a);
        regHit = (a == `DTB_OFF_CTRL0) || (a == `DTB_OFF_CTRL1) ||
                 (a == `DTB_OFF_STAT) || (a == `DTB_OFF_COUNT) ||
                 (a == `DTB_OFF_PERIOD) || (a == `DTB_OFF_DUTY1) ||
                 (a == `DTB_OFF_DUTY2);
    endfunction : regHit

    // Pure view of the state; reading never disturbs the counter.
    function automatic logic [31:0] regWord(input dtb_pkg::dtb_tmr_st_t s,
                                            input logic [`DTB_AW-1:0] a);
        logic [31:0] w;
        w = 32'h0;
        case (a)
            `DTB_OFF_CTRL0: begin
                w[`DTB_C0_RUN]  = s.run;
                w[`DTB_C0_MODE] = s.mode;
                w[`DTB_C0_TRIG] = s.trig;
                w[`DTB_C0_CLR]  = s.clrReq;
                w[`DTB_C0_SRC]  = s.srcExt;
                w[`DTB_C0_PSC]  = s.psc;
            end
            `DTB_OFF_CTRL1: begin
                w[`DTB_C1_SEL0] = s.sel0;
                w[`DTB_C1_INV0] = s.inv0;
                w[`DTB_C1_SEL1] = s.sel1;
                w[`DTB_C1_INV1] = s.inv1;
            end
            `DTB_OFF_STAT: begin
                w[`DTB_ST_OVF]  = s.ovf;
                w[`DTB_ST_IE]   = s.irqEn;
                w[`DTB_ST_PWM0] = s.raw0;
                w[`DTB_ST_PWM1] = s.raw1;
                w[`DTB_ST_DOWN] = (s.dir == dtb_pkg::DTB_DOWN);
            end
            `DTB_OFF_COUNT:  w[15:0] = s.cnt;
            `DTB_OFF_PERIOD: w[15:0] = s.period;
            `DTB_OFF_DUTY1:  w[15:0] = s.duty1;
            `DTB_OFF_DUTY2:  w[15:0] = s.duty2;
            default:         w = 32'h0;
        endcase
        regWord = w;
    endfunction : regWord

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] din,
                                          input logic [3:0]  strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        merge = m;
    endfunction : merge

    // Returns {match, next}: clears at the limit, and past it without a match.
    function automatic logic [8:0] stepByte(input logic [7:0] v,
                                            input logic [7:0] lim);
        if (v == lim) begin
            stepByte = {1'b1, 8'h00};
        end else if (v > lim) begin
            stepByte = {1'b0, 8'h00};
        end else begin
            stepByte = {1'b0, 8'(v + 8'h01)};
        end
    endfunction : stepByte

    // Set at the duty match, cleared at the period match, which wins a tie.
    function automatic logic pwmStep(input logic [2:0]  sel,
                                     input logic        cur,
                                     input logic [15:0] c,
                                     input logic [15:0] p,
                                     input logic [15:0] d1,
                                     input logic [15:0] d2);
        logic r;
        r = cur;
        case (sel)
            `DTB_WAVE_16A: begin
                if (c == d1) r = 1'b1;
                if (c == p) r = 1'b0;
            end
            `DTB_WAVE_16B: begin
                if (c == d2) r = 1'b1;
                if (c == p) r = 1'b0;
            end
            `DTB_WAVE_8LO: begin
                if (c[7:0] == d1[7:0]) r = 1'b1;
                if (c[7:0] == p[7:0]) r = 1'b0;
            end
            `DTB_WAVE_8HI: begin
                if (c[15:8] == d1[15:8]) r = 1'b1;
                if (c[15:8] == p[15:8]) r = 1'b0;
            end
            default: r = 1'b0;
        endcase
        pwmStep = r;
    endfunction : pwmStep

    dtb_axi_slave u_axi (
        .mclk          (mclk),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wrEn          (wrEn),
        .wrReq         (wrReq),
        .wrOk          (regHit(wrReq.addr)),
        .rdAddr        (rdAddr),
        .rdData        (regWord(st, rdAddr)),
        .rdOk          (regHit(rdAddr))
    );

    dtb_sync3 #(
        .W (2)
    ) u_sync (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .pinIn  ({trigPin, extClkPin}),
        .pinLvl (pinLvl)
    );

    logic        srcTick;
    logic        tick;
    logic        trigEdge;
    logic        counting;
    logic        ovfSet;
    logic [2:0]  pscLim;
    logic [8:0]  lo;
    logic [8:0]  hi;
    logic [15:0] c;
    logic [31:0] w;

    always_comb begin
        n          = st;
        ovfSet     = 1'b0;
        lo         = 9'h0;
        hi         = 9'h0;
        c          = st.cnt;
        w          = 32'h0;
        n.extPrev  = pinLvl[0];
        n.trigPrev = pinLvl[1];
        // Internal source ticks every cycle, external on its rising edge.
        srcTick = st.srcExt ? (pinLvl[0] && !st.extPrev) : 1'b1;
        pscLim  = 3'((4'h1 << st.psc) - 4'h1);
        tick    = 1'b0;
        if (st.run && srcTick) begin
            if (st.pscCnt >= pscLim) begin
                n.pscCnt = 3'h0;
                tick     = 1'b1;
            end else begin
                n.pscCnt = st.pscCnt + 3'h1;
            end
        end
        case (st.trig)
            dtb_pkg::DTB_TRG_RISE: trigEdge = pinLvl[1] && !st.trigPrev;
            dtb_pkg::DTB_TRG_FALL: trigEdge = !pinLvl[1] && st.trigPrev;
            dtb_pkg::DTB_TRG_ANY:  trigEdge = pinLvl[1] != st.trigPrev;
            default:               trigEdge = 1'b0;
        endcase
        if (!st.run) begin
            n.armed = 1'b0;
        end else if (trigEdge) begin
            n.armed = 1'b1;
        end
        counting = st.run && (st.trig == dtb_pkg::DTB_TRG_ALWAYS || st.armed);
        // Without counting the count and flag hold, except that a clear below zeroes the count and a write can clear the flag.
        if (counting && tick) begin
            case (st.mode)
                dtb_pkg::DTB_M16: begin
                    if (c >= st.period) begin
                        n.cnt  = 16'h0;
                        ovfSet = (c == st.period);
                    end else begin
                        n.cnt = c + 16'h1;
                    end
                end
                dtb_pkg::DTB_M17: begin
                    // The turn to counting down lands on the next tick.
                    if (st.dir == dtb_pkg::DTB_UP && c < st.period) begin
                        n.cnt = c + 16'h1;
                    end else if (st.dir == dtb_pkg::DTB_UP && c > st.period) begin
                        n.cnt = 16'h0;
                    end else begin
                        n.cnt = (c == 16'h0) ? 16'h0 : c - 16'h1;
                        n.dir = dtb_pkg::DTB_DOWN;
                        if (n.cnt == 16'h0) begin
                            ovfSet = 1'b1;
                            n.dir  = dtb_pkg::DTB_UP;
                        end
                    end
                end
                dtb_pkg::DTB_M8X2: begin
                    lo     = stepByte(c[7:0], st.period[7:0]);
                    hi     = stepByte(c[15:8], st.period[15:8]);
                    ovfSet = lo[8];
                    n.cnt  = {hi[7:0], lo[7:0]};
                end
                default: begin
                    lo     = stepByte(c[7:0], st.period[7:0]);
                    ovfSet = lo[8];
                    n.cnt  = {lo[8] ? 8'(c[15:8] + 8'h01) : c[15:8], lo[7:0]};
                end
            endcase
            n.raw0 = pwmStep(st.sel0, st.raw0, c, st.period, st.duty1, st.duty2);
            n.raw1 = pwmStep(st.sel1, st.raw1, c, st.period, st.duty1, st.duty2);
        end
        if (st.clrReq) begin
            n.cnt    = 16'h0;
            n.dir    = dtb_pkg::DTB_UP;
            n.pscCnt = 3'h0;
            n.raw0   = 1'b0;
            n.raw1   = 1'b0;
            n.clrReq = 1'b0;
        end
        // Writes touch configuration and the overflow flag only; the count is never loaded.
        if (wrEn) begin
            w = merge(regWord(st, wrReq.addr), wrReq.data, wrReq.strb);
            case (wrReq.addr)
                `DTB_OFF_CTRL0: begin
                    n.run    = w[`DTB_C0_RUN];
                    n.mode   = dtb_pkg::dtb_mode_t'(w[`DTB_C0_MODE]);
                    n.trig   = dtb_pkg::dtb_trig_t'(w[`DTB_C0_TRIG]);
                    n.clrReq = w[`DTB_C0_CLR];
                    n.srcExt = w[`DTB_C0_SRC];
                    n.psc    = w[`DTB_C0_PSC];
                end
                `DTB_OFF_CTRL1: begin
                    n.sel0 = w[`DTB_C1_SEL0];
                    n.inv0 = w[`DTB_C1_INV0];
                    n.sel1 = w[`DTB_C1_SEL1];
                    n.inv1 = w[`DTB_C1_INV1];
                end
                `DTB_OFF_STAT: begin
                    n.irqEn = w[`DTB_ST_IE];
                    if (wrReq.strb[0] && wrReq.data[`DTB_ST_OVF]) begin
                        n.ovf = 1'b0;
                    end
                end
                `DTB_OFF_PERIOD: n.period = w[15:0];
                `DTB_OFF_DUTY1:  n.duty1 = w[15:0];
                `DTB_OFF_DUTY2:  n.duty2 = w[15:0];
                default: ;
            endcase
        end
        // A new overflow in the same cycle as its clear is kept.
        if (ovfSet) begin
            n.ovf = 1'b1;
        end
        n.irq     = n.ovf && n.irqEn;
        n.pwmOut0 = n.run && (n.raw0 ^ n.inv0);
        n.pwmOut1 = n.run && (n.raw1 ^ n.inv1);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st        <= '0;
            st.period <= `DTB_RST_PERIOD;
            st.duty1  <= `DTB_RST_DUTY;
            st.duty2  <= `DTB_RST_DUTY;
            st.dir    <= dtb_pkg::DTB_UP;
        end else begin
            st <= n;
        end
    end

    assign pwmOut0 = st.pwmOut0;
    assign pwmOut1 = st.pwmOut1;
    assign irqReq  = st.irq;

endmodule : dtb_timer

// File: verification/dtb_timer_assertions.sv
`timescale 1ns/1ps

module dtb_timer_assertions (
    // Clock and reset.
    input wire logic       mclk,
    input wire logic       rst_n,
    // Write channels.
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bready,
    // Read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic       s_axi_rready
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence awTaken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence arTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_write_answer: assert property (awTaken |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    a_read_answer: assert property (arTaken |-> ##2 s_axi_rvalid)
        else $error("read response not on time");
    a_aw_refused: assert property (awTaken |=> !s_axi_awready)
        else $error("address accepted while busy");
    a_ar_refused: assert property (arTaken |=> !s_axi_arready)
        else $error("read address accepted while busy");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rresp))
        else $error("read response dropped");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid ##1 s_axi_awready)
        else $error("write response not retired");
    a_decerr_read: assert property ((arTaken and s_axi_araddr > 8'h18) |->
        ##2 s_axi_rresp == 2'h3)
        else $error("unmapped read not refused");
endmodule : dtb_timer_assertions

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "dtb_regs.svh"

module testbench;
    logic        mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, extClkPin, trigPin, pwmOut0, pwmOut1, irqReq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rv, cv, ctl0, ctl1, per, dty;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          num_errors, comparisons, p, h, t;

    dtb_timer dut_u (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .extClkPin, .trigPin, .pwmOut0, .pwmOut1, .irqReq);

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    // Starts from a rising output so that a pulse already under way is never half counted.
    task automatic meas(input int hi, input int per);
        int n;
        n = 0;
        while (pwmOut0 !== 1'b0) @(negedge mclk);
        while (pwmOut0 !== 1'b1) @(negedge mclk);
        while (pwmOut0 === 1'b1) begin
            @(negedge mclk);
            n++;
        end
        chk(n, hi);
        while (pwmOut0 === 1'b0) begin
            @(negedge mclk);
            n++;
        end
        chk(n, per);
    endtask : meas

    task conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        #2_000_000;
        num_errors++;
        conclude();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, extClkPin, trigPin, rst_n} = '0;
        s_axi_wstrb = 4'hf;
        seed = 32'h73ba;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`DTB_OFF_PERIOD, rv);
        chk(rv, 32'hffff);
        rd(8'h1c, rv);
        chk({30'h0, resp}, 32'h3);
        wr(8'h21, 32'h1);
        chk({30'h0, resp}, 32'h3);
        wr(`DTB_OFF_STAT, 32'h2);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            p = 8 + int'(seed % 24);
            seed = xs(seed);
            {ctl0, ctl1, per, dty} = {32'h1, 32'h0, 32'(p), seed % p};
            h = p - int'(dty);
            t = p + 1;
            case (i)
                1: begin ctl1 = 32'h8; h = int'(dty) + 1; end
                2: begin ctl0 = 32'h81; h = h * 2; t = t * 2; end
                3: begin
                    {ctl0, ctl1, per, dty, h, t} = {32'h5, 32'h3, 32'h406, 32'h203, 32'd2, 32'd5};
                end
                4: begin
                    {ctl0, ctl1, per, dty, h, t} = {32'h5, 32'h2, 32'h406, 32'h203, 32'd3, 32'd7};
                end
                5: begin
                    {ctl0, ctl1, per, dty} = {32'h7, 32'h3, 32'h401, 32'h201};
                    h = 4;
                    t = 512;
                end
                6: begin dty = per - 1; h = 1; end
                7: begin ctl0 = 32'h3; dty = 32'h0; h = p; t = 2 * p; end
                default: ;
            endcase
            wr(`DTB_OFF_CTRL0, 32'h20);
            repeat (2) @(negedge mclk);
            chk({31'h0, pwmOut0}, 32'h0);
            wr(`DTB_OFF_PERIOD, per);
            wr(`DTB_OFF_DUTY1, dty);
            wr(`DTB_OFF_CTRL1, ctl1);
            wr(`DTB_OFF_CTRL0, ctl0);
            meas(h, t);
            if (i == 0) chk({31'h0, irqReq}, 32'h1);
        end
        wr(`DTB_OFF_CTRL0, 32'h0);
        rd(`DTB_OFF_COUNT, rv);
        seed = xs(seed);
        wr(`DTB_OFF_COUNT, seed);
        chk({30'h0, resp}, 32'h0);
        rd(`DTB_OFF_COUNT, cv);
        chk(cv, rv);
        chk({31'h0, irqReq}, 32'h1);
        wr(`DTB_OFF_CTRL0, 32'h20);
        rd(`DTB_OFF_COUNT, rv);
        chk(rv, 32'h0);
        rd(`DTB_OFF_CTRL0, rv);
        chk(rv, 32'h0);
        wr(`DTB_OFF_STAT, 32'h3);
        repeat (2) @(negedge mclk);
        chk({31'h0, irqReq}, 32'h0);
        wr(`DTB_OFF_CTRL0, 32'h9);
        repeat (40) @(posedge mclk);
        chk({31'h0, irqReq}, 32'h0);
        trigPin <= 1'b1;
        repeat (60) @(posedge mclk);
        chk({31'h0, irqReq}, 32'h1);
        conclude();
    end
endmodule : testbench

bind dtb_timer dtb_timer_assertions chk_u (.mclk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rresp, .s_axi_rready);
